// [seq_angle_pkg.sv]
/*
 * Constants, register map and types for the axis sequencer and angle unit.
 * Assumes a 50 MHz system clock and 32-bit Avalon-MM register access.
 */
package seq_angle_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SLOT_TIME_NS = 50000;
    localparam int SLOT_CYCLES_INT = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] SLOT_LAST = 12'(SLOT_CYCLES_INT - 1);

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_GAIN = 6'h04;
    localparam logic [5:0] ADDR_STATUS = 6'h08;
    localparam logic [5:0] ADDR_IRQ_STAT = 6'h0C;
    localparam logic [5:0] ADDR_IRQ_MASK = 6'h10;
    localparam logic [5:0] ADDR_X_RES = 6'h14;
    localparam logic [5:0] ADDR_Y_RES = 6'h18;
    localparam logic [5:0] ADDR_Z_RES = 6'h1C;
    localparam logic [5:0] ADDR_ANGLE = 6'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_SEQ_LSB = 0;
    localparam int CTRL_PAIR_LSB = 4;
    localparam int CTRL_CONT_BIT = 8;
    localparam int CTRL_START_BIT = 9;
    localparam int CTRL_NOTIFY_BIT = 10;
    localparam int GAIN_FRAC_LSB = 0;
    localparam int GAIN_TGT_LSB = 11;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LATE_BIT = 1;
    localparam int GAIN_SHIFT = 10;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [3:0] SEQ_XZX = 4'hD;
    localparam logic [3:0] SEQ_YZY = 4'hE;
    localparam logic [3:0] SEQ_PLAIN_MAX = 4'h7;
    localparam logic [1:0] AXIS_X = 2'h0;
    localparam logic [1:0] AXIS_Y = 2'h1;
    localparam logic [1:0] AXIS_Z = 2'h2;
    localparam logic [1:0] GAIN_NONE = 2'h0;
    localparam logic [1:0] GAIN_X = 2'h1;
    localparam logic [1:0] GAIN_Y = 2'h2;
    localparam logic [1:0] PAIR_NONE = 2'h0;
    localparam logic [1:0] PAIR_XY = 2'h1;
    localparam logic [1:0] PAIR_YZ = 2'h2;
    localparam logic [1:0] PAIR_XZ = 2'h3;
    localparam logic [15:0] HALF_TURN = 16'h8000;
    localparam logic [3:0] CORDIC_LAST = 4'hD;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Arctangent of 2^-i, full turn = 65536
    localparam logic [15:0] ATAN_LUT [14] = '{
        16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146, 16'h00A3,
        16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005, 16'h0003, 16'h0001
    };

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_LOAD = 3'b010,
        ST_ROT = 3'b011,
        ST_DONE = 3'b100
    } seq_state_t;

endpackage : seq_angle_pkg

// [axis_sequencer_angle_gain.sv]
/*
 * Axis conversion sequencer with angle calculator and gain correction,
 * Avalon-MM register slave, sticky interrupts and a completion notify pin.
 * Assumes the analogue chain answers each conv_start with one adc_done
 * pulse inside the slot; all inputs are synchronous to clk.
 */
// Implementation choices: the register addresses and the Avalon-MM register port.
// How it works
// - Code 1101b converts X, then Z, then X again in back-to-back slots.
// - Fixed equal slots put Z completion exactly midway between both X completions.
// - Code 1110b runs the interleaved Y, Z, Y sequence.
// - Angle is computed from the axis pair chosen in the control register.
// - Angle result spans the full turn, 65536 codes per 360 degrees.
// - Gain fraction is unsigned, divided by 1024, multiplying the chosen axis at the angle input only.
// - Gain target 00b leaves all values uncorrected; fraction ignored.
// - Gain target 01b scales X, 10b scales Y.
// - Axis result registers change only at slot boundaries, not at adc_done.
// - Notify pin pulses once at sequence completion, after any angle calculation, when enabled.
`timescale 1ns/1ps
`default_nettype none

module axis_sequencer_angle_gain
    import seq_angle_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic notify,
    output logic conv_start,
    output logic [1:0] conv_axis,
    input wire logic adc_done,
    input wire logic [15:0] adc_data
);

    typedef struct packed {
        logic [3:0] seq_sel;
        logic [1:0] angle_pair;
        logic cont;
        logic notify_en;
        logic [9:0] gain_frac;
        logic [1:0] gain_target;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [15:0] x_res;
        logic [15:0] y_res;
        logic [15:0] z_res;
        logic [15:0] ang_res;
        logic [15:0] outer_first;
        logic [1:0] outer_axis;
        logic interleaved;
        seq_state_t st;
        logic [1:0] slot;
        logic [1:0] nslots;
        logic [5:0] list;
        logic [11:0] timer;
        logic got;
        logic [15:0] sample;
        logic signed [18:0] cx;
        logic signed [18:0] cy;
        logic [15:0] cz;
        logic [3:0] iter;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic notify;
        logic conv_start;
        logic [1:0] conv_axis;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Returns {slot count, three 2-bit axis codes, slot 0 in low bits}
    function automatic logic [7:0] seq_decode(input logic [3:0] code);
        logic [5:0] l;
        logic [1:0] n;
        l = 6'h00;
        n = 2'h0;
        if (code == SEQ_XZX) begin
            l = {AXIS_X, AXIS_Z, AXIS_X};
            n = 2'h3;
        end else if (code == SEQ_YZY) begin
            l = {AXIS_Y, AXIS_Z, AXIS_Y};
            n = 2'h3;
        end else if (code <= SEQ_PLAIN_MAX) begin
            for (int i = 2; i >= 0; i--) begin
                if (code[i]) begin
                    l = {l[3:0], 2'(i)};
                    n = n + 2'h1;
                end
            end
        end
        return {n, l};
    endfunction : seq_decode

    function automatic logic [15:0] scale(input logic [15:0] v, input logic [9:0] frac);
        logic signed [26:0] p;
        p = $signed(v) * $signed({1'b0, frac});
        return p[25:10];
    endfunction : scale

    logic [7:0] dec;
    logic req;
    logic accept;
    logic [31:0] bem;
    logic [31:0] cur;
    logic [31:0] wmerged;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [15:0] value;
    logic [1:0] axis_now;
    logic [15:0] ax_a;
    logic [15:0] ax_b;
    logic [1:0] sel_a;
    logic [1:0] sel_b;
    logic start_req;
    logic signed [18:0] sx;
    logic signed [18:0] sy;

    always_comb begin
        s_d = s_q;
        ev = 2'h0;
        clr = 2'h0;
        start_req = 1'b0;
        value = 16'h0000;
        ax_a = 16'h0000;
        ax_b = 16'h0000;
        sel_a = AXIS_X;
        sel_b = AXIS_Y;
        sx = 19'sd0;
        sy = 19'sd0;
        s_d.conv_start = 1'b0;
        s_d.notify = 1'b0;
        dec = seq_decode(s_q.seq_sel);
        axis_now = s_q.list[2 * s_q.slot +: 2];
        req = avs_read | avs_write;
        accept = req & ~s_q.waitreq;
        for (int i = 0; i < 4; i++) begin
            bem[8 * i +: 8] = {8{avs_byteenable[i]}};
        end

        // ************************************************************
        // Register bus
        // ************************************************************
        // One wait state: readdata is loaded as waitrequest drops
        unique case (avs_address)
            ADDR_CTRL: cur = 32'({s_q.notify_en, 1'b0, s_q.cont, 2'h0, s_q.angle_pair, s_q.seq_sel});
            ADDR_GAIN: cur = 32'({s_q.gain_target, 1'b0, s_q.gain_frac});
            ADDR_STATUS: cur = 32'(s_q.st != ST_IDLE);
            ADDR_IRQ_STAT: cur = 32'(s_q.irq_stat);
            ADDR_IRQ_MASK: cur = 32'(s_q.irq_mask);
            ADDR_X_RES: cur = 32'(s_q.x_res);
            ADDR_Y_RES: cur = 32'(s_q.y_res);
            ADDR_Z_RES: cur = 32'(s_q.z_res);
            ADDR_ANGLE: cur = 32'(s_q.ang_res);
            default: cur = RESET_WORD;
        endcase
        wmerged = (cur & ~bem) | (avs_writedata & bem);
        s_d.waitreq = ~(req & s_q.waitreq);
        if (req && s_q.waitreq) begin
            s_d.rdata = avs_read ? cur : RESET_WORD;
        end
        if (accept && avs_write) begin
            unique case (avs_address)
                ADDR_CTRL: begin
                    s_d.seq_sel = wmerged[CTRL_SEQ_LSB +: 4];
                    s_d.angle_pair = wmerged[CTRL_PAIR_LSB +: 2];
                    s_d.cont = wmerged[CTRL_CONT_BIT];
                    s_d.notify_en = wmerged[CTRL_NOTIFY_BIT];
                    start_req = wmerged[CTRL_START_BIT];
                end
                ADDR_GAIN: begin
                    s_d.gain_frac = wmerged[GAIN_FRAC_LSB +: 10];
                    s_d.gain_target = wmerged[GAIN_TGT_LSB +: 2];
                end
                ADDR_IRQ_STAT: clr = avs_byteenable[0] ? avs_writedata[1:0] : 2'h0;
                ADDR_IRQ_MASK: s_d.irq_mask = wmerged[1:0];
                default: ;
            endcase
        end

        // ************************************************************
        // Sequencer
        // ************************************************************
        unique case (s_q.st)
            ST_IDLE: begin
                // Only the sequence is sampled here; pair, gain and notify_en are read live, so mid-run changes apply to this run
                // Decode the code written with the start bit, not the old one
                dec = seq_decode(s_d.seq_sel);
                if ((start_req || s_q.cont) && dec[7:6] != 2'h0) begin
                    s_d.nslots = dec[7:6];
                    s_d.list = dec[5:0];
                    s_d.interleaved = (s_d.seq_sel == SEQ_XZX) || (s_d.seq_sel == SEQ_YZY);
                    s_d.outer_axis = dec[1:0];
                    s_d.slot = 2'h0;
                    s_d.timer = 12'h000;
                    s_d.got = 1'b0;
                    s_d.conv_start = 1'b1;
                    s_d.conv_axis = dec[1:0];
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (adc_done) begin
                    s_d.got = 1'b1;
                    s_d.sample = adc_data;
                end
                s_d.timer = s_q.timer + 12'h001;
                if (s_q.timer == SLOT_LAST) begin
                    // Commit on the slot boundary, not on adc_done, so that
                    // completions are evenly spaced whatever the ADC latency
                    value = adc_done ? adc_data : s_q.sample;
                    if (s_q.got || adc_done) begin
                        unique case (axis_now)
                            AXIS_X: s_d.x_res = value;
                            AXIS_Y: s_d.y_res = value;
                            default: s_d.z_res = value;
                        endcase
                        if (s_q.slot == 2'h0) begin
                            s_d.outer_first = value;
                        end
                    end else begin
                        ev[IRQ_LATE_BIT] = 1'b1;
                    end
                    if (s_q.slot == s_q.nslots - 2'h1) begin
                        s_d.st = (s_q.angle_pair != PAIR_NONE) ? ST_LOAD : ST_DONE;
                    end else begin
                        s_d.slot = s_q.slot + 2'h1;
                        s_d.timer = 12'h000;
                        s_d.got = 1'b0;
                        s_d.conv_start = 1'b1;
                        s_d.conv_axis = s_q.list[2 * (s_q.slot + 2'h1) +: 2];
                    end
                end
            end
            ST_LOAD: begin
                unique case (s_q.angle_pair)
                    PAIR_YZ: begin
                        sel_a = AXIS_Y;
                        sel_b = AXIS_Z;
                    end
                    PAIR_XZ: begin
                        sel_a = AXIS_X;
                        sel_b = AXIS_Z;
                    end
                    default: begin
                        sel_a = AXIS_X;
                        sel_b = AXIS_Y;
                    end
                endcase
                ax_a = (sel_a == AXIS_X) ? s_q.x_res : s_q.y_res;
                ax_b = (sel_b == AXIS_Z) ? s_q.z_res : s_q.y_res;
                // Outer axis of an interleaved run uses the mean of its two samples
                if (s_q.interleaved && sel_a == s_q.outer_axis) begin
                    ax_a = 16'((19'($signed(s_q.outer_first)) + 19'($signed(ax_a))) >>> 1);
                end
                if (s_q.interleaved && sel_b == s_q.outer_axis) begin
                    ax_b = 16'((19'($signed(s_q.outer_first)) + 19'($signed(ax_b))) >>> 1);
                end
                // Stored results stay raw; only the angle input is corrected
                if (s_q.gain_target == GAIN_X && sel_a == AXIS_X) begin
                    ax_a = scale(ax_a, s_q.gain_frac);
                end
                if (s_q.gain_target == GAIN_Y) begin
                    if (sel_a == AXIS_Y) begin
                        ax_a = scale(ax_a, s_q.gain_frac);
                    end else if (sel_b == AXIS_Y) begin
                        ax_b = scale(ax_b, s_q.gain_frac);
                    end
                end
                sx = 19'($signed(ax_a));
                sy = 19'($signed(ax_b));
                // Left half-plane is rotated by half a turn first
                if (sx < 0) begin
                    s_d.cx = -sx;
                    s_d.cy = -sy;
                    s_d.cz = HALF_TURN;
                end else begin
                    s_d.cx = sx;
                    s_d.cy = sy;
                    s_d.cz = 16'h0000;
                end
                s_d.iter = 4'h0;
                s_d.st = ST_ROT;
            end
            ST_ROT: begin
                if (s_q.cy >= 0) begin
                    s_d.cx = s_q.cx + (s_q.cy >>> s_q.iter);
                    s_d.cy = s_q.cy - (s_q.cx >>> s_q.iter);
                    s_d.cz = s_q.cz + ATAN_LUT[s_q.iter];
                end else begin
                    s_d.cx = s_q.cx - (s_q.cy >>> s_q.iter);
                    s_d.cy = s_q.cy + (s_q.cx >>> s_q.iter);
                    s_d.cz = s_q.cz - ATAN_LUT[s_q.iter];
                end
                s_d.iter = s_q.iter + 4'h1;
                if (s_q.iter == CORDIC_LAST) begin
                    s_d.ang_res = s_d.cz;
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                ev[IRQ_DONE_BIT] = 1'b1;
                s_d.notify = s_q.notify_en;
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase

        // ************************************************************
        // Interrupts
        // ************************************************************
        // A new event wins over a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign irq = s_q.irq;
    assign notify = s_q.notify;
    assign conv_start = s_q.conv_start;
    assign conv_axis = s_q.conv_axis;

endmodule : axis_sequencer_angle_gain

`default_nettype wire

// [seq_angle_properties.sv]
/* Port-level checker for axis_sequencer_angle_gain.
   Assumes one clock, synchronous active-high reset, bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
module seq_angle_checker
    import seq_angle_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic notify,
    input wire logic conv_start,
    input wire logic [1:0] conv_axis
);
    // ********************
    // Slot gap counter
    // ********************
    logic [11:0] gap_q;
    logic [11:0] gap_d;
    always_comb begin
        gap_d = gap_q;
        if (conv_start) begin
            gap_d = 12'h000;
        end else if (gap_q != 12'hFFF) begin
            gap_d = gap_q + 12'h001;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            gap_q <= 12'hFFF;
        end else begin
            gap_q <= gap_d;
        end
    end
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus request not answered in time");
    a_wait_only_req: assert property (!avs_waitrequest |-> (avs_read || avs_write))
        else $error("waitrequest low without a request");
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_rdata_hold: assert property (!(avs_read || avs_write) |=> $stable(avs_readdata))
        else $error("readdata changed without a request");
    a_slot_spacing: assert property (conv_start |-> gap_q >= SLOT_LAST)
        else $error("conversion slots closer than one slot time");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("conv_start longer than one cycle");
    a_axis_legal: assert property (conv_start |-> conv_axis != 2'h3)
        else $error("illegal axis code at conv_start");
    a_axis_change: assert property ($changed(conv_axis) |-> conv_start)
        else $error("conv_axis moved without conv_start");
    a_notify_pulse: assert property (notify |=> !notify)
        else $error("notify longer than one cycle");
    a_notify_late: assert property (notify |-> gap_q >= SLOT_LAST)
        else $error("notify before the last slot ended");
    c_z_slot: cover property (conv_start && conv_axis == AXIS_Z);
    c_notify: cover property (notify);
    c_irq: cover property ($rose(irq));
endmodule : seq_angle_checker
bind axis_sequencer_angle_gain seq_angle_checker chk (.clk(clk), .srst(srst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .notify(notify), .conv_start(conv_start), .conv_axis(conv_axis));
`default_nettype wire

// [adc_partner_model.sv]
/* Behavioural model of the analogue conversion chain.
   Assumes conv_start pulses come from the sequencer; delay and drop from the bench. */
`timescale 1ns/1ps
`default_nettype none
module adc_partner_model
    import seq_angle_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic conv_start,
    input wire logic [1:0] conv_axis,
    input wire logic [15:0] samp_x,
    input wire logic [15:0] samp_y,
    input wire logic [15:0] samp_z,
    input wire logic [11:0] delay,
    input wire logic drop,
    output logic adc_done,
    output logic [15:0] adc_data
);
    logic pend_q;
    logic [11:0] cnt_q;
    logic [1:0] axis_q;
    always_ff @(posedge clk) begin
        adc_done <= 1'b0;
        // Data inverts every cycle outside the valid cycle so stale values match only on alternate cycles
        adc_data <= ~adc_data;
        if (srst) begin
            pend_q <= 1'b0;
            adc_data <= 16'h0000;
        end else if (conv_start) begin
            pend_q <= 1'b1;
            cnt_q <= delay;
            axis_q <= conv_axis;
        end else if (pend_q && cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            if (!drop) begin
                adc_done <= 1'b1;
                adc_data <= (axis_q == AXIS_X) ? samp_x : (axis_q == AXIS_Y) ? samp_y : samp_z;
            end
        end
    end
endmodule : adc_partner_model
`default_nettype wire

// [axis_sequencer_angle_gain_tb_top.sv]
/* Self-checking bench for the sequencer: Avalon master, read monitor, ADC model.
   Assumes the designer's two-edge bus answer and 2500-cycle slots. */
`timescale 1ns/1ps
`default_nettype none
module axis_sequencer_angle_gain_tb_top
    import seq_angle_pkg::*;
;
    typedef struct { logic [31:0] exp; logic [1:0] mode; } note_t;
    logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, drop = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rng = 32'h0873;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, irq, notify, conv_start, adc_done;
    logic [1:0] conv_axis;
    logic [15:0] adc_data, sx = 16'h0, sy = 16'h0, sz = 16'h0;
    logic [11:0] dly = 12'h010;
    note_t notes[$];
    note_t cur;
    logic [1:0] ax_q[$];
    int t_q[$];
    int err_total = 0, checks_done = 0, cyc = 0;
    always #10 clk = ~clk;
    axis_sequencer_angle_gain dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .notify(notify),
        .conv_start(conv_start), .conv_axis(conv_axis), .adc_done(adc_done), .adc_data(adc_data));
    adc_partner_model adc (.clk(clk), .srst(srst), .conv_start(conv_start), .conv_axis(conv_axis),
        .samp_x(sx), .samp_y(sy), .samp_z(sz), .delay(dly), .drop(drop), .adc_done(adc_done),
        .adc_data(adc_data));
    // ********************
    // Checking and ending
    // ********************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xorshift
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (conv_start === 1'b1) begin
            ax_q.push_back(conv_axis);
            t_q.push_back(cyc);
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            cur = notes.pop_front();
            // Angle compared to the nearest 256 codes: the iterative solver is inexact
            if (cur.mode == 2'h1) check("readdata", avs_readdata, cur.exp);
            else if (cur.mode == 2'h2) check("angle", ((avs_readdata + 32'h80) >> 8) & 32'hFF, cur.exp);
        end
        if (cyc == 90000) begin
            err_total++;
            report_and_stop();
        end
    end
    // ********************
    // Bus and run tasks
    // ********************
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] m);
        notes.push_back('{exp: e, mode: m});
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic go(input logic [3:0] code, input logic [1:0] pair);
        ax_q.delete();
        t_q.delete();
        bus(ADDR_CTRL, 1'b1, 32'(code) | (32'(pair) << CTRL_PAIR_LSB) | (32'h1 << CTRL_START_BIT)
            | (32'h1 << CTRL_NOTIFY_BIT));
    endtask : go
    task automatic wait_done;
        for (int k = 0; k < 12000 && notify !== 1'b1; k++) @(posedge clk);
        check("notify", {31'h0, notify}, 32'h1);
    endtask : wait_done
    task automatic axes(input logic [1:0] a0, input logic [1:0] a1, input logic [1:0] a2);
        check("axis0", 32'(ax_q[0]), 32'(a0));
        check("axis1", 32'(ax_q[1]), 32'(a1));
        check("axis2", 32'(ax_q[2]), 32'(a2));
        check("gap1", 32'(t_q[1] - t_q[0]), 32'(SLOT_LAST) + 32'h1);
        check("gap2", 32'(t_q[2] - t_q[1]), 32'(SLOT_LAST) + 32'h1);
    endtask : axes
    // ********************
    // Scenarios
    // ********************
    logic [15:0] xa[4] = '{16'h0000, 16'hF000, 16'h0000, 16'h1000};
    logic [15:0] ya[4] = '{16'h1000, 16'h0000, 16'hF000, 16'h1000};
    logic [31:0] ea[4] = '{32'h40, 32'h80, 32'hC0, 32'h20};
    logic [1:0] gt[4] = '{GAIN_NONE, GAIN_X, GAIN_Y, 2'h3};
    logic [31:0] ge[4] = '{32'h20, 32'h2D, 32'h13, 32'h20};
    logic [5:0] ra[11] = '{ADDR_CTRL, ADDR_GAIN, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_X_RES,
        ADDR_Y_RES, ADDR_Z_RES, ADDR_ANGLE, 6'h24, 6'h02};
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) rd(ra[i], 32'h0, 2'h1);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h1);
        rd(ADDR_IRQ_MASK, 32'h1, 2'h1);
        sx <= 16'h1234;
        sz <= 16'h0567;
        go(SEQ_XZX, PAIR_NONE);
        repeat (100) @(posedge clk);
        rd(ADDR_X_RES, 32'h0, 2'h1);
        wait_done();
        axes(AXIS_X, AXIS_Z, AXIS_X);
        rd(ADDR_X_RES, 32'h1234, 2'h1);
        rd(ADDR_Z_RES, 32'h0567, 2'h1);
        check("irq", {31'h0, irq}, 32'h1);
        bus(ADDR_IRQ_STAT, 1'b1, 32'h1);
        for (int k = 0; k < 8 && irq !== 1'b0; k++) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        sy <= 16'h0ABC;
        go(SEQ_YZY, PAIR_YZ);
        wait_done();
        axes(AXIS_Y, AXIS_Z, AXIS_Y);
        rd(ADDR_Y_RES, 32'h0ABC, 2'h1);
        rd(ADDR_ANGLE, 32'h13, 2'h2);
        for (int i = 0; i < 4; i++) begin
            sx <= xa[i];
            sy <= ya[i];
            go(4'h3, PAIR_XY);
            wait_done();
            rd(ADDR_ANGLE, ea[i], 2'h2);
        end
        sy <= 16'h1000;
        sz <= 16'h0000;
        go(4'h6, PAIR_YZ);
        wait_done();
        rd(ADDR_ANGLE, 32'h00, 2'h2);
        sx <= 16'h0000;
        sz <= 16'h1000;
        go(4'h5, PAIR_XZ);
        wait_done();
        rd(ADDR_ANGLE, 32'h40, 2'h2);
        sx <= 16'h1000;
        for (int i = 0; i < 4; i++) begin
            bus(ADDR_GAIN, 1'b1, 32'h200 | (32'(gt[i]) << GAIN_TGT_LSB));
            rd(ADDR_GAIN, 32'h200 | (32'(gt[i]) << GAIN_TGT_LSB), 2'h1);
            go(4'h3, PAIR_XY);
            wait_done();
            rd(ADDR_ANGLE, ge[i], 2'h2);
            rd(ADDR_X_RES, 32'h1000, 2'h1);
        end
        bus(ADDR_IRQ_STAT, 1'b1, 32'h3);
        drop <= 1'b1;
        go(4'h1, PAIR_NONE);
        wait_done();
        drop <= 1'b0;
        rd(ADDR_IRQ_STAT, 32'h3, 2'h1);
        rd(ADDR_X_RES, 32'h1000, 2'h1);
        bus(ADDR_CTRL, 1'b1, 32'h1 | (32'h1 << CTRL_CONT_BIT) | (32'h1 << CTRL_NOTIFY_BIT));
        wait_done();
        bus(ADDR_CTRL, 1'b1, 32'h1 | (32'h1 << CTRL_NOTIFY_BIT));
        wait_done();
        go(4'h8, PAIR_NONE);
        repeat (20) @(posedge clk);
        check("starts", 32'(ax_q.size()), 32'h0);
        rd(ADDR_STATUS, 32'h0, 2'h1);
        for (int i = 0; i < 2; i++) begin
            rng = xorshift(rng);
            sx <= rng[15:0];
            dly <= {1'b0, rng[26:16]};
            go(4'h1, PAIR_NONE);
            wait_done();
            rd(ADDR_X_RES, {16'h0, rng[15:0]}, 2'h1);
        end
        bus(ADDR_IRQ_STAT, 1'b1, 32'h3);
        rd(ADDR_IRQ_STAT, 32'h0, 2'h1);
        report_and_stop();
    end
endmodule : axis_sequencer_angle_gain_tb_top
`default_nettype wire
